// ==== hdl/nvs_defines.svh ====
// Constants for the two-wire nonvolatile memory slave: array shape,
// register offsets, field positions and reset values.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef NVS_DEFINES_SVH
`define NVS_DEFINES_SVH

// Array shape
`define NVS_MEM_ADDR_W 15
`define NVS_MEM_DEPTH 32768
`define NVS_BYTE_W 8

// Serial bit counter values (count of rising edges in a byte slot)
`define NVS_BIT_LAST 4'h7
`define NVS_BIT_ACK 4'h8

// Slave address byte fields
`define NVS_SA_TYPE_MSB 7
`define NVS_SA_TYPE_LSB 4
`define NVS_SA_SEL_MSB 3
`define NVS_SA_SEL_LSB 1
`define NVS_SA_DIR_BIT 0

// Register bus
`define NVS_APB_AW 12
`define NVS_OFF_CTRL 12'h000
`define NVS_OFF_STATUS 12'h004
`define NVS_OFF_START_CNT 12'h008
`define NVS_OFF_STOP_CNT 12'h00c

// Register fields and reset values
`define NVS_CTRL_EN_BIT 0
`define NVS_CTRL_EN_RST 1'b1
`define NVS_STATUS_BUSY_BIT 0
`define NVS_STATUS_WP_BIT 1
`define NVS_STATUS_SEL_LSB 2
`define NVS_CNT_W 16

`endif

// ==== hdl/nvs_pkg.sv ====
// Types shared by the two-wire nonvolatile memory slave.
// Assumes nothing beyond a SystemVerilog compiler.
package nvs_pkg;

  // Protocol phase of the serial engine
  typedef enum logic [2:0] {
    NVS_ST_DEV,
    NVS_ST_MHI,
    NVS_ST_MLO,
    NVS_ST_WDATA,
    NVS_ST_RDATA,
    NVS_ST_IDLE
  } nvs_state_type;

  // Strap pins travel together through their synchronisers
  typedef struct packed {
    logic write_protect;
    logic [2:0] device_select_pins;
  } nvs_strap_type;

  // Filtered bus lines as seen from the register clock
  typedef struct packed {
    logic scl;
    logic sda;
  } nvs_line_type;

endpackage

// ==== hdl/nvs_sync.sv ====
// Three-stage synchroniser with agreement filter.
// Assumes asynchronous inputs; output moves once stages two and three agree.
`timescale 1ns/1ns
module nvs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("nvs_sync needs WIDTH of at least one");
  end

  // Only stages two and three feed the filter; stage one is metastable
  always_comb begin
    out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;

endmodule // nvs_sync

// ==== hdl/nvs_serial_mem.sv ====
// Two-wire serial slave for a byte-wide nonvolatile memory array, with
// an APB status and control block on the register clock.
// Assumes scl is the master's clock, which may stop between frames, and
// that the pad resolves the open-drain data line and the strap pulls.
//
// Contract
// - The array holds 32,768 bytes of 8 bits, moved serially over the link.
// - The device answers only when the three select bits equal its select pins.
// - Unconnected select pins read as zero through an internal pull-down.
// - The data line is only ever pulled low or released.
// - Incoming data is sampled on scl rising and outgoing data changes on scl falling.
// - A high write-protect pin blocks every array write; low leaves all writable.
// - An unconnected write-protect pin reads low, so the array stays writable.
// - A 16-bit memory address is taken and only its low 15 bits select a location.
// - Each array write completes before the next transaction can arrive.
// - Interface logic starts from a power-on reset and there is no other reset input.
// - The first byte is type in bits 7..4, select in 3..1 and direction in bit 0.
// - The address latch advances after each byte before the acknowledge and wraps to zero.
// - A read sends the next byte on master acknowledge and ends on its absence.
// - A data byte is written after its eighth bit; a start or stop before that aborts it.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "nvs_defines.svh"
module nvs_serial_mem #(
  parameter int ADDR_W = `NVS_MEM_ADDR_W,
  parameter int MEM_DEPTH = `NVS_MEM_DEPTH,
  parameter logic [3:0] DEVICE_TYPE = 4'h3 // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`NVS_APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire nvs_pkg::nvs_strap_type strap_pins
);
  import nvs_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr
    $error("ADDR_W must lie between 9 and 16");
  end
  if (MEM_DEPTH != (1 << ADDR_W)) begin : g_bad_depth
    $error("MEM_DEPTH must equal two to the power ADDR_W");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [`NVS_CNT_W-1:0] CNT_ONE = `NVS_CNT_W'(1);

  nvs_line_type line_f;
  nvs_line_type line_prev_reg;
  nvs_line_type line_prev_next;
  nvs_strap_type strap_ps;
  nvs_strap_type strap_lk;
  logic start_det;
  logic stop_det;
  logic start_pulse_reg;
  logic start_pulse_next;
  logic stop_pulse_reg;
  logic stop_pulse_next;
  logic busy_reg;
  logic busy_next;
  logic ctrl_en_reg;
  logic ctrl_en_next;
  logic [`NVS_CNT_W-1:0] start_cnt_reg;
  logic [`NVS_CNT_W-1:0] start_cnt_next;
  logic [`NVS_CNT_W-1:0] stop_cnt_reg;
  logic [`NVS_CNT_W-1:0] stop_cnt_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic slverr_reg;
  logic slverr_next;
  logic apb_setup;
  logic apb_write;
  logic link_clr;
  logic stop_clr;
  logic armed_reg;
  nvs_state_type state_reg;
  nvs_state_type state_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [`NVS_BYTE_W-1:0] shift_reg;
  logic [`NVS_BYTE_W-1:0] shift_next;
  logic [`NVS_BYTE_W-1:0] tx_reg;
  logic [`NVS_BYTE_W-1:0] tx_next;
  logic [`NVS_BYTE_W-1:0] hi_reg;
  logic [`NVS_BYTE_W-1:0] hi_next;
  logic rw_reg;
  logic rw_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [`NVS_BYTE_W-1:0] byte_in;
  logic [`NVS_BYTE_W-1:0] mem_q;
  logic mem_we;
  logic sel_match;
  logic drive_reg;
  logic drive_next;
  logic [`NVS_BYTE_W-1:0] mem [MEM_DEPTH];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bus lines into the register clock for start and stop detection
  nvs_sync #(.WIDTH(2)) u_line_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({scl, sda_in}),
    .dout(line_f)
  );

  // Straps into the register clock, for status only
  nvs_sync #(.WIDTH(4)) u_strap_ps_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(strap_pins),
    .dout(strap_ps)
  );

  // Straps into the link clock; unconnected pins are held low by the pad pulls
  nvs_sync #(.WIDTH(4)) u_strap_lk_sync (
    .clk(scl),
    .rst_n(presetn),
    .din(strap_pins),
    .dout(strap_lk)
  );

  // ----------------------------------------------------------------
  // Start and stop detection on the register clock
  // ----------------------------------------------------------------
  // Both lines pass equal sync depth, so our own release after scl falls
  // cannot look like a stop; a disabled block ignores starts but still counts stops
  assign start_det = ctrl_en_reg & line_f.scl & line_prev_reg.scl
                     & line_prev_reg.sda & ~line_f.sda;
  assign stop_det = line_f.scl & line_prev_reg.scl & ~line_prev_reg.sda & line_f.sda;

  always_comb begin
    line_prev_next = line_f;
    start_pulse_next = start_det;
    stop_pulse_next = stop_det;
    busy_next = busy_reg;
    if (start_det) begin
      busy_next = 1'b1;
    end else if (stop_det) begin
      busy_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_reg <= '0;
      start_pulse_reg <= 1'b0;
      stop_pulse_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      line_prev_reg <= line_prev_next;
      start_pulse_reg <= start_pulse_next;
      stop_pulse_reg <= stop_pulse_next;
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;

  // Read data and error are decoded in setup so both come from flops
  always_comb begin
    prdata_next = prdata_reg;
    slverr_next = 1'b0;
    ctrl_en_next = ctrl_en_reg;
    start_cnt_next = start_cnt_reg;
    stop_cnt_next = stop_cnt_reg;
    if (apb_setup) begin
      prdata_next = '0;
      unique case (paddr)
        `NVS_OFF_CTRL: prdata_next[`NVS_CTRL_EN_BIT] = ctrl_en_reg;
        `NVS_OFF_STATUS: begin
          prdata_next[`NVS_STATUS_BUSY_BIT] = busy_reg;
          prdata_next[`NVS_STATUS_WP_BIT] = strap_ps.write_protect;
          prdata_next[`NVS_STATUS_SEL_LSB +: 3] = strap_ps.device_select_pins;
        end
        `NVS_OFF_START_CNT: prdata_next[`NVS_CNT_W-1:0] = start_cnt_reg;
        `NVS_OFF_STOP_CNT: prdata_next[`NVS_CNT_W-1:0] = stop_cnt_reg;
        default: slverr_next = 1'b1;
      endcase
    end else if (psel) begin
      slverr_next = slverr_reg;
    end
    // Any write to a counter clears it; a same-cycle event still counts
    if (apb_write && paddr == `NVS_OFF_CTRL && pstrb[0]) begin
      ctrl_en_next = pwdata[`NVS_CTRL_EN_BIT];
    end
    if (apb_write && paddr == `NVS_OFF_START_CNT) begin
      start_cnt_next = '0;
    end
    if (apb_write && paddr == `NVS_OFF_STOP_CNT) begin
      stop_cnt_next = '0;
    end
    if (start_det) begin
      start_cnt_next = start_cnt_next + CNT_ONE;
    end
    if (stop_det) begin
      stop_cnt_next = stop_cnt_next + CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      slverr_reg <= 1'b0;
      ctrl_en_reg <= `NVS_CTRL_EN_RST;
      start_cnt_reg <= '0;
      stop_cnt_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
      ctrl_en_reg <= ctrl_en_next;
      start_cnt_reg <= start_cnt_next;
      stop_cnt_reg <= stop_cnt_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = slverr_reg & psel & penable;

  // ----------------------------------------------------------------
  // Frame control crossing into the link clock
  // ----------------------------------------------------------------
  // The link clock stands still at start and stop, so those events reach
  // the link logic as asynchronous clears driven from flops, not as data.
  // Power-on reset is the only external reset source.
  assign link_clr = ~presetn | start_pulse_reg | stop_pulse_reg;
  assign stop_clr = ~presetn | stop_pulse_reg;

  // Armed from start to stop; until armed the engine ignores scl
  always_ff @(posedge scl or posedge stop_clr or posedge start_pulse_reg) begin
    if (stop_clr) begin
      armed_reg <= 1'b0;
    end else if (start_pulse_reg) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= armed_reg;
    end
  end

  // ----------------------------------------------------------------
  // Serial engine on scl rising edges
  // ----------------------------------------------------------------
  assign byte_in = {shift_reg[`NVS_BYTE_W-2:0], sda_in};
  assign mem_q = mem[addr_reg];
  assign sel_match =
    byte_in[`NVS_SA_TYPE_MSB:`NVS_SA_TYPE_LSB] == DEVICE_TYPE
    && byte_in[`NVS_SA_SEL_MSB:`NVS_SA_SEL_LSB] == strap_lk.device_select_pins;

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    hi_next = hi_reg;
    rw_next = rw_reg;
    addr_next = addr_reg;
    mem_we = 1'b0;
    if (armed_reg) begin
      unique case (state_reg)
        NVS_ST_RDATA: begin
          if (bit_reg == `NVS_BIT_ACK) begin
            bit_next = '0;
            if (!sda_in) begin
              tx_next = mem_q;
            end else begin
              state_next = NVS_ST_IDLE;
            end
          end else begin
            tx_next = {tx_reg[`NVS_BYTE_W-2:0], 1'b1};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == `NVS_BIT_LAST) begin
              addr_next = addr_reg + ADDR_W'(1);
            end
          end
        end
        NVS_ST_IDLE: begin
          bit_next = bit_reg;
        end
        default: begin
          if (bit_reg == `NVS_BIT_ACK) begin
            // Acknowledge slot finished: move on to the next byte
            bit_next = '0;
            if (state_reg == NVS_ST_DEV) begin
              if (rw_reg) begin
                state_next = NVS_ST_RDATA;
                tx_next = mem_q;
              end else begin
                state_next = NVS_ST_MHI;
              end
            end else if (state_reg == NVS_ST_MHI) begin
              state_next = NVS_ST_MLO;
            end else begin
              state_next = NVS_ST_WDATA;
            end
          end else begin
            shift_next = byte_in;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == `NVS_BIT_LAST) begin
              if (state_reg == NVS_ST_DEV) begin
                if (sel_match) begin
                  rw_next = byte_in[`NVS_SA_DIR_BIT];
                end else begin
                  state_next = NVS_ST_IDLE;
                end
              end else if (state_reg == NVS_ST_MHI) begin
                hi_next = byte_in;
              end else if (state_reg == NVS_ST_MLO) begin
                // Top received bit is dropped by the width of the latch
                addr_next = {hi_reg[ADDR_W-9:0], byte_in};
              end else begin
                mem_we = ~strap_lk.write_protect;
                addr_next = addr_reg + ADDR_W'(1);
              end
            end
          end
        end
      endcase
    end
  end

  // Frame state restarts at every start and stop
  always_ff @(posedge scl or posedge link_clr) begin
    if (link_clr) begin
      state_reg <= NVS_ST_DEV;
      bit_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      hi_reg <= '0;
      rw_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      hi_reg <= hi_next;
      rw_reg <= rw_next;
    end
  end

  // The address latch survives frames so a later read uses it
  always_ff @(posedge scl or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // Write lands on the eighth rising edge, long before the next byte
  always_ff @(posedge scl) begin
    if (mem_we) begin
      mem[addr_reg] <= byte_in;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain driver on scl falling edges
  // ----------------------------------------------------------------
  // Drive low for a zero read bit or an acknowledge; release otherwise
  always_comb begin
    drive_next = 1'b0;
    if (armed_reg) begin
      unique case (state_reg)
        NVS_ST_RDATA: drive_next = (bit_reg != `NVS_BIT_ACK) && !tx_reg[`NVS_BYTE_W-1];
        NVS_ST_IDLE: drive_next = 1'b0;
        default: drive_next = (bit_reg == `NVS_BIT_ACK);
      endcase
    end
  end

  always_ff @(negedge scl or posedge link_clr) begin
    if (link_clr) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_reg;

endmodule // nvs_serial_mem

// ==== dv/nvs_serial_mem_sva.sv ====
// Port-level checker for the two-wire memory slave.
// Assumes a master that holds psel high through the access phase.
`timescale 1ns/1ns
`include "nvs_defines.svh"
module nvs_serial_mem_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`NVS_APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe
);
  import nvs_pkg::*;
  // ----------------
  // Decode helpers
  // ----------------
  logic acc;
  logic mapped;
  // Offsets outside the four words must be refused
  assign acc = psel && penable;
  assign mapped = paddr inside {`NVS_OFF_CTRL, `NVS_OFF_STATUS, `NVS_OFF_START_CNT,
    `NVS_OFF_STOP_CNT};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  pready_high_a: assert property (pready)
    else $error("wait state inserted");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  ctrl_bits_a: assert property (acc && paddr == `NVS_OFF_CTRL |-> prdata[31:1] == 31'h0)
    else $error("unused control bits set");
  // The serial clock is slow, so a pclk view of it catches changes while high
  oe_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data output moved while clock high");
  reset_quiet_a: assert property (disable iff (1'b0)
    !presetn |-> !sda_oe && !pslverr && prdata == 32'h0)
    else $error("outputs active in reset");
endmodule // nvs_serial_mem_sva
bind nvs_serial_mem nvs_serial_mem_sva u_nvs_serial_mem_sva (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe));

// ==== dv/nvs_master_model.sv ====
// Two-wire bus master model: makes scl and pulls the data line low.
// Assumes a pull-up on the data line; scl stands high between frames.
`timescale 1ns/1ns
module nvs_master_model #(
  parameter int HALF = 100
) (
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  int n_start;
  int n_stop;
  // Idle bus with both lines released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    n_start = 0;
    n_stop = 0;
  end
  // One clock pulse; data moves well after the fall to keep away from scl high
  task automatic pulse(output logic got);
    #(HALF - 30);
    scl = 1'b1;
    #(HALF / 2);
    got = sda;
    #(HALF / 2);
    scl = 1'b0;
    #30;
  endtask
  // Start, or repeated start when scl is low
  task automatic bus_start();
    if (!scl) begin
      sda_pull = 1'b0;
      #(HALF - 30);
      scl = 1'b1;
      #HALF;
    end
    sda_pull = 1'b1;
    n_start++;
    #HALF;
    scl = 1'b0;
    #30;
  endtask
  task automatic bus_stop();
    sda_pull = 1'b1;
    #(HALF - 30);
    scl = 1'b1;
    #HALF;
    sda_pull = 1'b0;
    n_stop++;
    #HALF;
  endtask
  // Top n bits msb first; the ack slot only follows a whole byte
  task automatic put_bits(input logic [7:0] b, input int n, output logic ack);
    logic got;
    for (int i = 7; i > 7 - n; i--) begin
      sda_pull = !b[i];
      pulse(got);
    end
    ack = 1'b1;
    if (n == 8) begin
      sda_pull = 1'b0;
      pulse(ack);
    end
  endtask
  task automatic get_byte(output logic [7:0] b, input logic more);
    logic got;
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(got);
      b[i] = got;
    end
    sda_pull = more;
    pulse(got);
  endtask
endmodule // nvs_master_model

// ==== dv/testbench.sv ====
// Self-checking bench for the two-wire memory slave and its APB block.
// Assumes the master model makes scl; the bench resolves the data line.
`timescale 1ns/1ns
`include "nvs_defines.svh"
module testbench;
  import nvs_pkg::*;
  localparam logic [3:0] DEV_TYPE = 4'h9; // Arbitrary type code
  logic pclk = 1'b0;
  logic presetn;
  logic [11:0] paddr = 12'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic [2:0] sel = 3'h0;
  nvs_strap_type strap = '0;
  int num_errors = 0;
  int checks_done = 0;
  // Pull-up: the line is low only while someone pulls it
  wire logic sda = !((sda_oe && !sda_out) || sda_pull);
  always #5 pclk = !pclk;
  nvs_serial_mem #(.DEVICE_TYPE(DEV_TYPE)) u_nvs_serial_mem (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_pins(strap));
  nvs_master_model u_nvs_master_model (.sda(sda), .scl(scl), .sda_pull(sda_pull));
  // -----------------
  // Checks and bus
  // -----------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // Answer is taken at the rising edge that sees pready; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check_word(rd, exp);
    check_bit(err, e);
  endtask
  function automatic logic [7:0] sa(input logic [2:0] s, input logic rd);
    return {DEV_TYPE, s, rd};
  endfunction
  task automatic put_ok(input logic [7:0] b);
    logic ack;
    u_nvs_master_model.put_bits(b, 8, ack);
    check_bit(ack, 1'b0);
  endtask
  task automatic probe(input logic [7:0] b);
    logic ack;
    u_nvs_master_model.bus_start();
    u_nvs_master_model.put_bits(b, 8, ack);
    u_nvs_master_model.bus_stop();
    check_bit(ack, 1'b1);
  endtask
  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    u_nvs_master_model.bus_start();
    put_ok(sa(sel, 1'b0));
    put_ok(a[15:8]);
    put_ok(a[7:0]);
    put_ok(d0);
    put_ok(d1);
    u_nvs_master_model.bus_stop();
  endtask
  // Random read: address by a write, then a repeated start; nack ends it
  task automatic mem_rd(input logic [15:0] a, output logic [15:0] rr);
    u_nvs_master_model.bus_start();
    put_ok(sa(sel, 1'b0));
    put_ok(a[15:8]);
    put_ok(a[7:0]);
    u_nvs_master_model.bus_start();
    put_ok(sa(sel, 1'b1));
    u_nvs_master_model.get_byte(rr[15:8], 1'b1);
    u_nvs_master_model.get_byte(rr[7:0], 1'b0);
    u_nvs_master_model.bus_stop();
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 100 us of traffic
  initial begin
    #500000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  // ------------
  // Test flow
  // ------------
  initial begin
    logic [31:0] rd;
    logic err;
    logic [15:0] rr;
    logic ack;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`NVS_OFF_CTRL, 32'h1, 1'b0);
    rdchk(`NVS_OFF_STATUS, 32'h0, 1'b0);
    rdchk(`NVS_OFF_START_CNT, 32'h0, 1'b0);
    apb(1'b1, `NVS_OFF_STATUS, 32'hffff_ffff, rd, err);
    check_bit(err, 1'b0);
    rdchk(`NVS_OFF_STATUS, 32'h0, 1'b0);
    rdchk(12'h010, 32'h0, 1'b1);
    apb(1'b1, 12'h010, 32'h1, rd, err);
    check_bit(err, 1'b1);
    apb(1'b1, `NVS_OFF_STOP_CNT, 32'h0, rd, err);
    $display("registers done");
    mem_wr(16'h9234, 8'ha5, 8'h3c);
    mem_rd(16'h1234, rr);
    check_word({16'h0, rr}, 32'ha53c);
    mem_wr(16'h7fff, 8'h11, 8'h22);
    mem_rd(16'h7fff, rr);
    check_word({16'h0, rr}, 32'h1122);
    $display("write read wrap done");
    @(posedge pclk);
    strap.device_select_pins <= 3'h5;
    sel = 3'h5;
    probe(sa(3'h0, 1'b0));
    probe({~DEV_TYPE, sel, 1'b0});
    mem_wr(16'h1236, 8'h5a, 8'h6b);
    rdchk(`NVS_OFF_STATUS, 32'h14, 1'b0);
    $display("select done");
    @(posedge pclk);
    strap.write_protect <= 1'b1;
    mem_wr(16'h1234, 8'h00, 8'hff);
    rdchk(`NVS_OFF_STATUS, 32'h16, 1'b0);
    u_nvs_master_model.bus_start();
    put_ok(sa(sel, 1'b1));
    u_nvs_master_model.get_byte(rr[7:0], 1'b0);
    u_nvs_master_model.bus_stop();
    check_word({24'h0, rr[7:0]}, 32'h5a);
    mem_rd(16'h1234, rr);
    check_word({16'h0, rr}, 32'ha53c);
    $display("protect done");
    @(posedge pclk);
    strap.write_protect <= 1'b0;
    u_nvs_master_model.bus_start();
    put_ok(sa(sel, 1'b0));
    put_ok(8'h12);
    put_ok(8'h34);
    u_nvs_master_model.put_bits(8'hee, 4, ack);
    u_nvs_master_model.bus_stop();
    mem_rd(16'h1234, rr);
    check_word({16'h0, rr}, 32'ha53c);
    $display("abort done");
    // A control write without its low byte lane must leave the enable alone
    @(posedge pclk);
    pstrb <= 4'he;
    apb(1'b1, `NVS_OFF_CTRL, 32'h0, rd, err);
    pstrb <= 4'hf;
    rdchk(`NVS_OFF_CTRL, 32'h1, 1'b0);
    apb(1'b1, `NVS_OFF_CTRL, 32'h0, rd, err);
    probe(sa(sel, 1'b0));
    apb(1'b1, `NVS_OFF_CTRL, 32'h1, rd, err);
    rdchk(`NVS_OFF_START_CNT, 32'(u_nvs_master_model.n_start - 1), 1'b0);
    rdchk(`NVS_OFF_STOP_CNT, 32'(u_nvs_master_model.n_stop), 1'b0);
    $display("enable and counters done");
    final_report();
  end
endmodule // testbench
